// ---- hdl/mltcr_pkg.sv ----
// Constants for the interrupt-message and link timer configuration register bank.
// Assumes a 32-bit APB slave in one clock domain.
// Notes on behaviour
// [RULE1] Interrupt-message header identifier reads 05h
// [RULE2] Interrupt-message next pointer reads 64h
// [RULE3] Message enable gates messages, blocks legacy pin
// [RULE4] 64-bit address capable bit reads one
// [RULE5] Message address writable above bit 1
// [RULE6] Upper address used only when 64-bit selected; the code always uses it (use64 tied to 1)
// [RULE7] Vendor header identifier reads 09h
// [RULE8] Vendor next pointer reads B0h
// [RULE9] Vendor length field defaults to 0034h
// [RULE10] Writable 12-bit replay value, reset zero
// [RULE11] Replay enable selects user replay value
// [RULE12] Writable 14-bit ack latency, reset zero
// [RULE13] Ack enable selects user latency value
// [RULE14] Override defaults reloadable by SMBus or EEPROM
// [RULE15] Top ack bit reports VGA decode enable
// [RULE16] Interrupt issues memory write with data
package mltcr_pkg;
  localparam logic [7:0]  ADDR_MSG_CAP    = 8'h4c;
  localparam logic [7:0]  ADDR_MSG_ADDR   = 8'h50;
  localparam logic [7:0]  ADDR_MSG_UPPER  = 8'h54;
  localparam logic [7:0]  ADDR_MSG_DATA   = 8'h58;
  localparam logic [7:0]  ADDR_VEND_CAP   = 8'h64;
  localparam logic [7:0]  ADDR_SCRATCH0   = 8'h68;
  localparam logic [7:0]  ADDR_SCRATCH1   = 8'h6c;
  localparam logic [7:0]  ADDR_TIMERS     = 8'h70;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h80;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h84;
  localparam logic [7:0]  MSG_CAP_ID      = 8'h05;
  localparam logic [7:0]  MSG_NEXT_PTR    = 8'h64;
  localparam logic [2:0]  MULTI_MSG_CAP   = 3'h2;
  localparam logic [7:0]  VEND_CAP_ID     = 8'h09;
  localparam logic [7:0]  VEND_NEXT_PTR   = 8'hb0;
  localparam logic [15:0] VEND_LEN_RST    = 16'h0034;
  localparam logic [31:0] SCRATCH0_RST    = 32'h0400_1060;
  localparam logic [31:0] SCRATCH1_RST    = 32'h0000_0800;
  localparam int          MSG_EN_BIT      = 16;
  localparam int          MME_LSB         = 20;
  localparam int          ADDR64_BIT      = 23;
  localparam int          REPLAY_EN_BIT   = 12;
  localparam int          PM_DIS_BIT      = 13;
  localparam int          MSI_DIS_BIT     = 14;
  localparam int          ACK_LSB         = 16;
  localparam int          ACK_EN_BIT      = 30;
  localparam int          VGA_BIT         = 31;
  localparam int          IRQ_BITS        = 2;
  localparam int          IRQ_MSG_SENT    = 0;
  localparam int          IRQ_DFLT_LOAD   = 1;
endpackage

// ---- hdl/mltcr_regs.sv ----
// Interrupt-message capability, vendor header and link timer override registers.
// Assumes an APB master on core_clk_in; default loader and message sink are on-chip.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module mltcr_regs
  import mltcr_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        dflt_load_in,
  input  wire logic [11:0] dflt_replay_in,
  input  wire logic        dflt_replay_en_in,
  input  wire logic [13:0] dflt_ack_in,
  input  wire logic        dflt_ack_en_in,
  input  wire logic        dflt_pm_dis_in,
  input  wire logic        dflt_msi_dis_in,
  input  wire logic        vga_decode_in,
  input  wire logic        irq_req_in,
  output logic             intx_req_out,
  output logic             msg_wr_out,
  input  wire logic        msg_wr_done_in,
  output logic      [63:0] msg_wr_addr_out,
  output logic      [15:0] msg_wr_data_out,
  output logic      [11:0] replay_timeout_out,
  output logic      [13:0] ack_latency_out,
  output logic             use_user_replay_out,
  output logic             use_user_ack_out,
  output logic             irq_out
);
  logic                msg_en_r;
  logic [2:0]          mme_r;
  logic [29:0]         maddr_r;
  logic [31:0]         mupper_r;
  logic [15:0]         mdata_r;
  logic [31:0]         scr0_r;
  logic [31:0]         scr1_r;
  logic [11:0]         replay_r;
  logic                replay_en_r;
  logic [13:0]         ack_r;
  logic                ack_en_r;
  logic                pm_dis_r;
  logic                msi_dis_r;
  logic                pend_r;
  logic [IRQ_BITS-1:0] stat_r;
  logic [IRQ_BITS-1:0] mask_r;
  logic [IRQ_BITS-1:0] stat_nxt;
  logic [31:0]         rdata_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        old[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return old;
  endfunction

  wire        acc     = psel_in && penable_in && clk_en_in;
  wire        wr      = acc && pwrite_in;
  wire        rd      = acc && !pwrite_in;
  wire [31:0] ctl_old = {8'h00, 1'b1, mme_r, MULTI_MSG_CAP, msg_en_r, 16'h0000};
  wire [31:0] tim_old = {1'b0, ack_en_r, ack_r, 1'b0, msi_dis_r, pm_dis_r, replay_en_r, replay_r};
  wire [31:0] wmix    = merge(32'h0000_0000, pwdata_in, pstrb_in);
  wire [31:0] ctl_w   = merge(ctl_old, pwdata_in, pstrb_in);
  wire [31:0] tim_w   = merge(tim_old, pwdata_in, pstrb_in);
  wire [31:0] addr_w  = merge({maddr_r, 2'b00}, pwdata_in, pstrb_in);
  wire [31:0] upp_w   = merge(mupper_r, pwdata_in, pstrb_in);
  wire [31:0] dat_w   = merge({16'h0000, mdata_r}, pwdata_in, pstrb_in);
  wire [31:0] s0_w    = merge(scr0_r, pwdata_in, pstrb_in);
  wire [31:0] s1_w    = merge(scr1_r, pwdata_in, pstrb_in);
  wire        mapped  = (paddr_in == ADDR_MSG_CAP) || (paddr_in == ADDR_MSG_ADDR) ||
                        (paddr_in == ADDR_MSG_UPPER) || (paddr_in == ADDR_MSG_DATA) ||
                        (paddr_in == ADDR_VEND_CAP) || (paddr_in == ADDR_SCRATCH0) ||
                        (paddr_in == ADDR_SCRATCH1) || (paddr_in == ADDR_TIMERS) ||
                        (paddr_in == ADDR_IRQ_STAT) || (paddr_in == ADDR_IRQ_MASK);
  wire        msg_ok  = msg_en_r && !msi_dis_r;
  wire        use64   = 1'b1;
  wire        sent    = pend_r && msg_wr_done_in;
  wire        stat_rd = rd && (paddr_in == ADDR_IRQ_STAT);

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr_in)
      ADDR_MSG_CAP:   rdata_nxt = {ctl_old[31:16], MSG_NEXT_PTR, MSG_CAP_ID}; // [RULE1] [RULE2] [RULE4]
      ADDR_MSG_ADDR:  rdata_nxt = {maddr_r, 2'b00}; // [RULE5]
      ADDR_MSG_UPPER: rdata_nxt = mupper_r;
      ADDR_MSG_DATA:  rdata_nxt = {16'h0000, mdata_r};
      ADDR_VEND_CAP:  rdata_nxt = {VEND_LEN_RST, VEND_NEXT_PTR, VEND_CAP_ID}; // [RULE7] [RULE8] [RULE9]
      ADDR_SCRATCH0:  rdata_nxt = scr0_r;
      ADDR_SCRATCH1:  rdata_nxt = scr1_r;
      ADDR_TIMERS:    rdata_nxt = {vga_decode_in, tim_old[30:0]}; // [RULE15]
      ADDR_IRQ_STAT:  rdata_nxt = {{(32-IRQ_BITS){1'b0}}, stat_r};
      ADDR_IRQ_MASK:  rdata_nxt = {{(32-IRQ_BITS){1'b0}}, mask_r};
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end
  assign prdata_out = rdata_nxt;

  // Message path
  assign intx_req_out        = irq_req_in && !msg_ok; // [RULE3]
  assign msg_wr_out          = pend_r; // [RULE16]
  assign msg_wr_addr_out     = {(use64 ? mupper_r : 32'h0000_0000), maddr_r, 2'b00}; // [RULE6]
  assign msg_wr_data_out     = mdata_r; // [RULE16]
  assign replay_timeout_out  = replay_r;
  assign ack_latency_out     = ack_r;
  assign use_user_replay_out = replay_en_r; // [RULE11]
  assign use_user_ack_out    = ack_en_r; // [RULE13]

  // Sticky status, set beats read clear
  assign stat_nxt = (stat_rd ? '0 : stat_r) | {dflt_load_in, sent};
  assign irq_out  = |(stat_r & mask_r);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      msg_en_r    <= 1'b0; // [RULE3]
      mme_r       <= 3'h0;
      maddr_r     <= 30'h0000_0000;
      mupper_r    <= 32'h0000_0000;
      mdata_r     <= 16'h0000;
      scr0_r      <= SCRATCH0_RST;
      scr1_r      <= SCRATCH1_RST;
      replay_r    <= 12'h000; // [RULE10]
      replay_en_r <= 1'b0;
      ack_r       <= 14'h0000; // [RULE12]
      ack_en_r    <= 1'b0;
      pm_dis_r    <= 1'b0;
      msi_dis_r   <= 1'b0;
      pend_r      <= 1'b0;
      stat_r      <= '0;
      mask_r      <= '0;
    end else if (clk_en_in) begin
      stat_r <= stat_nxt;
      if (sent) begin
        pend_r <= 1'b0;
      end else if (irq_req_in && msg_ok) begin
        pend_r <= 1'b1; // [RULE16]
      end
      if (dflt_load_in) begin
        replay_r    <= dflt_replay_in; // [RULE14]
        replay_en_r <= dflt_replay_en_in;
        ack_r       <= dflt_ack_in;
        ack_en_r    <= dflt_ack_en_in;
        pm_dis_r    <= dflt_pm_dis_in;
        msi_dis_r   <= dflt_msi_dis_in;
      end else if (wr && paddr_in == ADDR_TIMERS) begin
        replay_r    <= tim_w[11:0]; // [RULE10]
        replay_en_r <= tim_w[REPLAY_EN_BIT];
        ack_r       <= tim_w[ACK_EN_BIT-1:ACK_LSB]; // [RULE12]
        ack_en_r    <= tim_w[ACK_EN_BIT];
      end
      if (wr) begin
        case (paddr_in)
          ADDR_MSG_CAP: begin
            msg_en_r <= ctl_w[MSG_EN_BIT]; // [RULE3]
            mme_r    <= ctl_w[MME_LSB +: 3];
          end
          ADDR_MSG_ADDR:  maddr_r  <= addr_w[31:2]; // [RULE5]
          ADDR_MSG_UPPER: mupper_r <= upp_w;
          ADDR_MSG_DATA:  mdata_r  <= dat_w[15:0];
          ADDR_SCRATCH0:  scr0_r   <= s0_w;
          ADDR_SCRATCH1:  scr1_r   <= s1_w;
          ADDR_IRQ_MASK:  mask_r   <= wmix[IRQ_BITS-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  cap_id_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE1]
    (paddr_in == ADDR_MSG_CAP) |-> (prdata_out[15:0] == 16'h6405 && prdata_out[ADDR64_BIT]))
    else $error("message header bytes wrong");
  vend_hdr_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE8]
    (paddr_in == ADDR_VEND_CAP) |-> (prdata_out == 32'h0034_b009))
    else $error("vendor header wrong");
  intx_block_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE3]
    (msg_en_r && !msi_dis_r) |-> !intx_req_out)
    else $error("legacy pin used while messages enabled");
  msg_fire_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE16]
    (clk_en_in && irq_req_in && msg_ok && !pend_r) |=> msg_wr_out)
    else $error("message write not raised");
  addr_write_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE5]
    (wr && paddr_in == ADDR_MSG_ADDR && pstrb_in == 4'hf) |=> (msg_wr_addr_out[31:0] == {$past(pwdata_in[31:2]), 2'b00}))
    else $error("message address not stored");
  replay_sel_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE11]
    (wr && !dflt_load_in && paddr_in == ADDR_TIMERS && pstrb_in[1]) |=> (use_user_replay_out == $past(pwdata_in[12])))
    else $error("replay enable not stored");
  ack_val_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE12]
    (wr && !dflt_load_in && paddr_in == ADDR_TIMERS && pstrb_in == 4'hf) |=> (ack_latency_out == $past(pwdata_in[29:16])))
    else $error("ack latency not stored");
  dflt_load_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE14]
    (clk_en_in && dflt_load_in) |=> (replay_timeout_out == $past(dflt_replay_in) && stat_r[IRQ_DFLT_LOAD]))
    else $error("default load not applied");
  vga_flag_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [RULE15]
    (paddr_in == ADDR_TIMERS) |-> (prdata_out[VGA_BIT] == vga_decode_in))
    else $error("VGA flag wrong");
endmodule
`default_nettype wire

// ---- test/mltcr_sink.sv ----
// Memory-write sink that answers interrupt messages after a delay.
// Assumes the bank holds its request until the done pulse.
`timescale 1ns/10ps
`default_nettype none
module mltcr_sink #(
  parameter int DLY = 3
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        req_in,
  input  wire logic [63:0] addr_in,
  input  wire logic [15:0] data_in,
  output logic             done_out,
  output logic      [63:0] got_addr_out,
  output logic      [15:0] got_data_out,
  output logic             seen_out
);
  int cnt;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt      <= 0;
      done_out <= 1'b0;
      seen_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (req_in && !done_out) begin
        if (cnt == DLY) begin
          done_out     <= 1'b1;
          cnt          <= 0;
          got_addr_out <= addr_in;
          got_data_out <= data_in;
          seen_out     <= 1'b1;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/mltcr_regs_tb_top.sv ----
// Register bank bench: APB sequences with expected values.
// Assumes zero-wait APB and the sink model on the message port.
`timescale 1ns/10ps
`default_nettype none
module mltcr_regs_tb_top;
  import mltcr_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ld = 0, ren = 0, aen = 0;
  logic        pmd = 0, msd = 0, vga = 0, irq = 0, done, pready, perr, intx, mwr, iout, uur, uua, seen;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [11:0] rv = 0, rto;
  logic [13:0] av = 0, alo;
  logic [63:0] maddr, gaddr;
  logic [15:0] mdata, gdata;
  logic        e;
  logic        ce = 1;
  int          bad_count = 0, check_count = 0, n;
  initial forever #2.5 clk = ~clk;
  mltcr_regs i_mltcr_regs (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hf), .prdata_out(prd),
    .pready_out(pready), .pslverr_out(perr), .dflt_load_in(ld), .dflt_replay_in(rv), .dflt_replay_en_in(ren),
    .dflt_ack_in(av), .dflt_ack_en_in(aen), .dflt_pm_dis_in(pmd), .dflt_msi_dis_in(msd), .vga_decode_in(vga),
    .irq_req_in(irq), .intx_req_out(intx), .msg_wr_out(mwr), .msg_wr_done_in(done), .msg_wr_addr_out(maddr),
    .msg_wr_data_out(mdata), .replay_timeout_out(rto), .ack_latency_out(alo), .use_user_replay_out(uur),
    .use_user_ack_out(uua), .irq_out(iout));
  mltcr_sink i_mltcr_sink (.clk_in(clk), .rst_in(rst), .req_in(mwr), .addr_in(maddr), .data_in(mdata),
    .done_out(done), .got_addr_out(gaddr), .got_data_out(gdata), .seen_out(seen));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      bad_count++;
      wrap_up();
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h4c, 32'h0084_6405);
    rd(8'h64, 32'h0034_b009);
    rd(8'h70, 32'h0000_0000);
    rd(8'h50, 32'h0); rd(8'h54, 32'h0); rd(8'h58, 32'h0); rd(8'h80, 32'h0); rd(8'h84, 32'h0);
    rd(8'h68, 32'h0400_1060); rd(8'h6c, 32'h0000_0800);
    $display("test reset done");
    apb(1'b1, 8'h50, 32'h1000_0013); rd(8'h50, 32'h1000_0010);
    apb(1'b1, 8'h58, 32'hffff_abcd); rd(8'h58, 32'h0000_abcd);
    ce <= 1'b0;
    apb(1'b1, 8'h58, 32'h0000_1111);
    ce <= 1'b1;
    rd(8'h58, 32'h0000_abcd);
    apb(1'b1, 8'h70, 32'hffff_ffff); rd(8'h70, 32'h7fff_1fff);
    chk({uur, uua, rto, alo}, {2'b11, 12'hfff, 14'h3fff});
    apb(1'b1, 8'h90, 32'h1); chk(e, 1'b1);
    rd(8'h90, 32'h0);
    $display("test write done");
    irq <= 1'b1;
    @(negedge clk); chk({intx, mwr}, 2'b10);
    @(posedge clk) irq <= 1'b0;
    apb(1'b1, 8'h54, 32'h1234_5678); apb(1'b1, 8'h84, 32'h3);
    apb(1'b1, 8'h4c, 32'hffff_ffff); rd(8'h4c, 32'h00f5_6405);
    @(posedge clk) irq <= 1'b1;
    @(negedge clk) chk(intx, 1'b0);
    @(posedge clk) irq <= 1'b0;
    for (n = 0; n < 50 && seen !== 1'b1; n++) @(negedge clk);
    if (n == 50) begin
      bad_count++;
      wrap_up();
    end
    chk({gaddr, gdata}, {64'h1234_5678_1000_0010, 16'habcd});
    repeat (2) @(negedge clk); chk(iout, 1'b1);
    rd(8'h80, 32'h1);
    @(negedge clk); chk(iout, 1'b0);
    $display("test message done");
    @(posedge clk) begin
      vga <= 1'b1; rv <= 12'h5a5; ren <= 1'b1; av <= 14'h2bcd; aen <= 1'b0; pmd <= 1'b1; msd <= 1'b1; ld <= 1'b1;
    end
    @(posedge clk) ld <= 1'b0;
    rd(8'h70, 32'habcd_75a5);
    chk({uur, uua, rto, alo}, {2'b10, 12'h5a5, 14'h2bcd});
    rd(8'h80, 32'h2);
    $display("test default load done");
    wrap_up();
  end
endmodule
`default_nettype wire
